// File: hdl/mqf_pkg.sv
// Shared constants and carrier types for the multi-queue flow-control FIFO.
// Assumes a single 50 MHz clock and synchronous configuration straps.
package mqf_pkg;

  // Queue space and memory geometry.
  localparam int unsigned MAX_QUEUES   = 32;
  localparam int unsigned QA_W         = 5;
  localparam int unsigned WORD_W       = 36;
  localparam int unsigned PORT_W       = 36;
  localparam int unsigned BLOCK_WORDS  = 256;
  localparam int unsigned TOTAL_BLOCKS = 8;
  localparam int unsigned MEM_WORDS    = TOTAL_BLOCKS * BLOCK_WORDS;
  localparam int unsigned MEM_AW       = 11;
  localparam int unsigned CNT_W        = 12;
  localparam int unsigned BLK_W        = 8;
  localparam int unsigned PKT_W        = 8;

  // Flag status buses.
  localparam int unsigned STAT_W       = 8;
  localparam int unsigned STAT_WORDS   = 4;
  localparam int unsigned SW_W         = 2;

  // Default configuration values.
  localparam int unsigned DEF_QUEUES   = 8;
  localparam logic [CNT_W-1:0] DEF_AF_OFFSET = 12'h008;
  localparam logic [CNT_W-1:0] DEF_AE_OFFSET = 12'h008;

  // Serial configuration record: blocks, almost-full and almost-empty offsets.
  localparam int unsigned REC_W        = 32;
  localparam int unsigned REC_BLK_LSB  = 24;
  localparam int unsigned REC_AF_LSB   = 12;
  localparam int unsigned REC_AE_LSB   = 0;

  // Packet demarcation bits inside a stored word.
  localparam int unsigned SOP_BIT      = 8;
  localparam int unsigned EOP_BIT      = 17;

  // Staging buffer on the write path.
  localparam int unsigned STAGE_DEPTH  = 32;
  localparam int unsigned STAGE_W      = QA_W + WORD_W;

  typedef enum logic [1:0] {
    MQF_PROG_DEFAULT  = 2'h0,
    MQF_PROG_SERIAL   = 2'h1,
    MQF_PROG_PARALLEL = 2'h2
  } mqf_prog_mode_t;

  typedef enum logic [1:0] {
    MQF_W9  = 2'h0,
    MQF_W18 = 2'h1,
    MQF_W36 = 2'h2
  } mqf_width_t;

  // Setup pins caught while master reset is low.
  typedef struct packed {
    mqf_prog_mode_t prog_mode;
    logic           polled;
    logic           packet_mode;
    logic           master;
    mqf_width_t     in_width;
    mqf_width_t     out_width;
  } mqf_strap_t;

  // Dedicated flags of the selected queues.
  typedef struct packed {
    logic queue_full_flag;
    logic almost_full_flag;
    logic queue_empty_flag;
    logic almost_empty_flag;
    logic packet_ready_n;
  } mqf_flags_t;

endpackage

// File: hdl/mqf_top.sv
// Multi-queue FIFO: staging buffer and the queue engine with its ports.
// Assumes all inputs are synchronous to clock and that master_reset_n is
// pulsed low once before use.
`timescale 1ns/1ps
`default_nettype none

module mqf_stage_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wptr;
    logic [PW:0] rptr;
  } mqf_fifo_state_t;

  mqf_fifo_state_t st_q, st_d;
  logic [WIDTH-1:0] store [DEPTH];

  // Full when the pointers differ only in the wrap bit.
  assign in_ready  = (st_q.wptr ^ st_q.rptr) != {1'b1, {PW{1'b0}}};
  assign out_valid = st_q.wptr != st_q.rptr;
  assign out_data  = store[st_q.rptr[PW-1:0]];

  always_comb begin
    st_d = st_q;
    if (in_valid && in_ready) begin
      st_d.wptr = st_q.wptr + 1'b1;
    end
    if (out_valid && out_ready) begin
      st_d.rptr = st_q.rptr + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      store[st_q.wptr[PW-1:0]] <= in_data;
    end
  end
endmodule

// What this block does
// - Each accepted write goes to the queue named on the write address.
// - Reads take data from the queue named on the read address.
// - Write and read ports work independently, same or different queues.
// - Full flag follows the write-selected queue, empty the read-selected.
// - Every queue has its own almost-full and almost-empty threshold.
// - Two 8-bit status buses report almost-full and almost-empty states.
// - Up to 8 queues, each queue owns one bit of each bus.
// - Above 8 queues the buses show status words, polled or direct.
// - Input and output widths are 9, 18 or 36 bits, set separately.
// - Width conversion packs and unpacks units little-endian.
// - In packet mode packet_ready_n goes low when a whole packet waits.
// - A packet counts once its start and end marks have been written.
// - Packet counts are kept for every queue.
// - One to 32 queues, each with its own depth.
// - Configuration enters only through the serial programming port.
// - Without programming, a fixed default configuration applies.
// - Operating and programming modes latch at master reset release.
// - Master or slave expansion role latches at master reset release.
// - Queue storage is given out in blocks of 256 words.
// - Polled status words advance one step on every rising clock edge.
// - Direct mode shows the status word the user addresses.
// - Switching reads to an empty queue leaves the old word on output.
module mqf_top
  import mqf_pkg::*;
(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire logic                        master_reset_n,
  // Setup pins
  input  wire mqf_pkg::mqf_strap_t         strap,
  // Serial programming port
  input  wire logic                        serial_enable,
  input  wire logic                        serial_data,
  output logic                             config_done,
  output logic                             expansion_master,
  // Write port
  input  wire logic [mqf_pkg::QA_W-1:0]    write_queue_address,
  input  wire logic                        write_enable,
  input  wire logic [mqf_pkg::PORT_W-1:0]  write_data,
  output logic                             write_ready,
  // Read port
  input  wire logic [mqf_pkg::QA_W-1:0]    read_queue_address,
  input  wire logic                        read_enable,
  output logic [mqf_pkg::PORT_W-1:0]       read_data,
  output logic                             read_valid,
  // Flags
  output mqf_pkg::mqf_flags_t              flags,
  // Status buses
  input  wire logic [mqf_pkg::SW_W-1:0]    af_status_select,
  input  wire logic [mqf_pkg::SW_W-1:0]    ae_status_select,
  output logic [mqf_pkg::STAT_W-1:0]       almost_full_status_bus,
  output logic [mqf_pkg::STAT_W-1:0]       almost_empty_status_bus,
  output logic [mqf_pkg::SW_W-1:0]         af_status_word,
  output logic [mqf_pkg::SW_W-1:0]         ae_status_word
);
  import mqf_pkg::*;

  typedef enum logic [2:0] {
    CFG_RESET  = 3'b001,
    CFG_SERIAL = 3'b010,
    CFG_RUN    = 3'b100
  } mqf_cfg_t;

  typedef struct packed {
    mqf_cfg_t                                cfg;
    mqf_strap_t                              strap;
    logic [QA_W:0]                           nq;
    logic [MAX_QUEUES-1:0][BLK_W-1:0]        blocks;
    logic [MAX_QUEUES-1:0][CNT_W-1:0]        af_off;
    logic [MAX_QUEUES-1:0][CNT_W-1:0]        ae_off;
    logic [MAX_QUEUES-1:0][MEM_AW-1:0]       wptr;
    logic [MAX_QUEUES-1:0][MEM_AW-1:0]       rptr;
    logic [MAX_QUEUES-1:0][CNT_W-1:0]        res_cnt;
    logic [MAX_QUEUES-1:0][CNT_W-1:0]        word_cnt;
    logic [MAX_QUEUES-1:0][PKT_W-1:0]        pkt_cnt;
    logic [MAX_QUEUES-1:0]                   in_pkt;
    logic [WORD_W-1:0]                       pack_word;
    logic [1:0]                              pack_idx;
    logic [QA_W-1:0]                         pack_q;
    logic [1:0]                              unpack_idx;
    logic [QA_W-1:0]                         unpack_q;
    logic [REC_W-1:0]                        shift;
    logic [4:0]                              bit_cnt;
    logic [QA_W:0]                           rec_idx;
    logic                                    ser_en_prev;
    logic [SW_W-1:0]                         af_poll;
    logic [SW_W-1:0]                         ae_poll;
    logic [PORT_W-1:0]                       rdata;
    logic                                    rvalid;
    logic                                    wready;
    mqf_flags_t                              flags;
    logic [STAT_W-1:0]                       af_bus;
    logic [STAT_W-1:0]                       ae_bus;
    logic [SW_W-1:0]                         af_word;
    logic [SW_W-1:0]                         ae_word;
  } mqf_state_t;

  mqf_state_t st_q, st_d;
  logic [WORD_W-1:0] mem [MEM_WORDS];

  logic                  stage_in_valid;
  logic                  stage_in_ready;
  logic [STAGE_W-1:0]    stage_in_data;
  logic                  stage_out_valid;
  logic                  stage_out_ready;
  logic [STAGE_W-1:0]    stage_out_data;
  logic                  mem_we;
  logic [MEM_AW-1:0]     mem_waddr;
  logic [MEM_AW-1:0]     mem_raddr;
  logic [MAX_QUEUES-1:0][MEM_AW-1:0] base;
  logic [MAX_QUEUES-1:0] af_vec;
  logic [MAX_QUEUES-1:0] ae_vec;
  logic [MAX_QUEUES-1:0][15:0] qsize;

  // Staged writes decouple packing from the shared memory port.
  mqf_stage_fifo #(
    .WIDTH (STAGE_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (stage_in_valid),
    .in_ready  (stage_in_ready),
    .in_data   (stage_in_data),
    .out_valid (stage_out_valid),
    .out_ready (stage_out_ready),
    .out_data  (stage_out_data)
  );

  // Queues sit back to back in memory, each a whole number of blocks.
  always_comb begin
    logic [15:0] acc;
    acc = '0;
    for (int i = 0; i < MAX_QUEUES; i++) begin
      base[i]  = acc[MEM_AW-1:0];
      qsize[i] = (i < st_q.nq) ? {st_q.blocks[i], 8'h00} : 16'h0000;
      acc      = acc + qsize[i];
      // Reserved count includes staged words, so the flags never overbook.
      af_vec[i] = (qsize[i] != 16'h0000) &&
                  ({4'h0, st_q.res_cnt[i]} + {4'h0, st_q.af_off[i]} >=
                   qsize[i]);
      ae_vec[i] = st_q.word_cnt[i] <= st_q.ae_off[i];
    end
  end

  assign mem_raddr = base[read_queue_address] +
                     st_q.rptr[read_queue_address];

  always_comb begin
    logic [QA_W-1:0]   wq;
    logic [QA_W-1:0]   rq;
    logic [QA_W-1:0]   dq;
    logic [WORD_W-1:0] dword;
    logic [WORD_W-1:0] rword;
    logic [1:0]        pidx;
    logic [1:0]        uidx;
    logic              w_ok;
    logic              w_last;
    logic              r_ok;
    logic              r_last;
    logic              run;
    logic              q_full;
    logic              q_empty;
    logic [MEM_AW-1:0] nxt;
    wq     = write_queue_address;
    rq     = read_queue_address;
    dq     = stage_out_data[STAGE_W-1 -: QA_W];
    dword  = stage_out_data[WORD_W-1:0];
    rword  = mem[mem_raddr];
    run    = st_q.cfg == CFG_RUN;
    nxt    = '0;
    st_d   = st_q;
    mem_we = 1'b0;
    mem_waddr = '0;
    stage_in_valid  = 1'b0;
    stage_in_data   = '0;
    stage_out_ready = 1'b0;
    q_full  = ({1'b0, wq} >= st_q.nq) ||
              ({4'h0, st_q.res_cnt[wq]} >= qsize[wq]);
    q_empty = ({1'b0, rq} >= st_q.nq) || (st_q.word_cnt[rq] == '0);

    // Write port: pack units little-endian into a stored word.
    pidx   = (wq == st_q.pack_q) ? st_q.pack_idx : 2'h0;
    w_ok   = run && write_enable && !q_full && stage_in_ready;
    w_last = 1'b0;
    if (w_ok) begin
      st_d.pack_q = wq;
      unique case (st_q.strap.in_width)
        MQF_W9: begin
          st_d.pack_word[9*pidx +: 9] = write_data[8:0];
          w_last = pidx == 2'h3;
        end
        MQF_W18: begin
          st_d.pack_word[18*pidx[0] +: 18] = write_data[17:0];
          w_last = pidx[0];
        end
        default: begin
          st_d.pack_word = write_data;
          w_last = 1'b1;
        end
      endcase
      st_d.pack_idx = w_last ? 2'h0 : pidx + 2'h1;
      if (w_last) begin
        stage_in_valid = 1'b1;
        stage_in_data  = {wq, st_d.pack_word};
        st_d.res_cnt[wq] = st_q.res_cnt[wq] + 1'b1;
      end
    end

    // Read port: unpack the head word of the selected queue.
    uidx   = (rq == st_q.unpack_q) ? st_q.unpack_idx : 2'h0;
    r_ok   = run && read_enable && !q_empty;
    r_last = 1'b0;
    st_d.rvalid = 1'b0;
    if (r_ok) begin
      st_d.unpack_q = rq;
      st_d.rvalid   = 1'b1;
      st_d.rdata    = '0;
      unique case (st_q.strap.out_width)
        MQF_W9: begin
          st_d.rdata[8:0] = rword[9*uidx +: 9];
          r_last = uidx == 2'h3;
        end
        MQF_W18: begin
          st_d.rdata[17:0] = rword[18*uidx[0] +: 18];
          r_last = uidx[0];
        end
        default: begin
          st_d.rdata = rword;
          r_last = 1'b1;
        end
      endcase
      st_d.unpack_idx = r_last ? 2'h0 : uidx + 2'h1;
      if (r_last) begin
        nxt = st_q.rptr[rq] + 1'b1;
        st_d.rptr[rq] = ({5'h00, nxt} == qsize[rq]) ? '0 : nxt;
        st_d.word_cnt[rq] = st_q.word_cnt[rq] - 1'b1;
        st_d.res_cnt[rq]  = st_d.res_cnt[rq] - 1'b1;
        if (rword[EOP_BIT] && st_q.pkt_cnt[rq] != '0) begin
          st_d.pkt_cnt[rq] = st_q.pkt_cnt[rq] - 1'b1;
        end
      end
    end
    // Without a read the output word is held, also across queue changes.

    // Drain: the memory has one port, so a read wins the cycle and the
    // staging buffer waits, which is where back-pressure builds up.
    if (run && !r_ok && stage_out_valid) begin
      stage_out_ready = 1'b1;
      mem_we    = 1'b1;
      mem_waddr = base[dq] + st_q.wptr[dq];
      nxt = st_q.wptr[dq] + 1'b1;
      st_d.wptr[dq] = ({5'h00, nxt} == qsize[dq]) ? '0 : nxt;
      st_d.word_cnt[dq] = st_q.word_cnt[dq] + 1'b1;
      if (dword[SOP_BIT]) begin
        st_d.in_pkt[dq] = 1'b1;
      end
      if (dword[EOP_BIT] && (st_q.in_pkt[dq] || dword[SOP_BIT])) begin
        st_d.in_pkt[dq]  = 1'b0;
        st_d.pkt_cnt[dq] = st_q.pkt_cnt[dq] + 1'b1;
      end
    end

    // Configuration sequencing after master reset.
    unique case (st_q.cfg)
      CFG_RESET: begin
        if (st_q.strap.prog_mode == MQF_PROG_SERIAL) begin
          st_d.cfg = CFG_SERIAL;
        end else begin
          st_d.cfg = CFG_RUN;
          st_d.nq  = (QA_W+1)'(DEF_QUEUES);
          for (int i = 0; i < MAX_QUEUES; i++) begin
            st_d.blocks[i] = (i < DEF_QUEUES) ?
                             BLK_W'(TOTAL_BLOCKS / DEF_QUEUES) : '0;
            st_d.af_off[i] = DEF_AF_OFFSET;
            st_d.ae_off[i] = DEF_AE_OFFSET;
          end
        end
      end
      CFG_SERIAL: begin
        st_d.ser_en_prev = serial_enable;
        if (serial_enable) begin
          st_d.shift   = {st_q.shift[REC_W-2:0], serial_data};
          st_d.bit_cnt = st_q.bit_cnt + 1'b1;
          if (st_q.bit_cnt == 5'h1f) begin
            st_d.blocks[st_q.rec_idx[QA_W-1:0]] =
              st_d.shift[REC_BLK_LSB +: BLK_W];
            st_d.af_off[st_q.rec_idx[QA_W-1:0]] =
              st_d.shift[REC_AF_LSB +: CNT_W];
            st_d.ae_off[st_q.rec_idx[QA_W-1:0]] =
              st_d.shift[REC_AE_LSB +: CNT_W];
            st_d.rec_idx = st_q.rec_idx + 1'b1;
            st_d.nq      = st_q.rec_idx + 1'b1;
            if (st_q.rec_idx == (QA_W+1)'(MAX_QUEUES - 1)) begin
              st_d.cfg = CFG_RUN;
            end
          end
        end else if (st_q.ser_en_prev && st_q.rec_idx != '0) begin
          st_d.cfg = CFG_RUN;
        end
      end
      CFG_RUN: begin
        st_d.cfg = CFG_RUN;
      end
    endcase

    // Dedicated flags follow the currently addressed queues.
    st_d.wready                  = w_ok || (run && !q_full &&
                                            stage_in_ready);
    st_d.flags.queue_full_flag   = q_full;
    st_d.flags.queue_empty_flag  = q_empty;
    st_d.flags.almost_full_flag  = af_vec[wq] || q_full;
    st_d.flags.almost_empty_flag = ae_vec[rq];
    st_d.flags.packet_ready_n    = !(st_q.strap.packet_mode &&
                                     st_q.pkt_cnt[rq] != '0);

    // Status buses: eight queues per word.
    if (st_q.nq <= (QA_W+1)'(STAT_W)) begin
      st_d.af_word = '0;
      st_d.ae_word = '0;
    end else if (st_q.strap.polled) begin
      st_d.af_poll = st_q.af_poll + 1'b1;
      st_d.ae_poll = st_q.ae_poll + 1'b1;
      st_d.af_word = st_q.af_poll;
      st_d.ae_word = st_q.ae_poll;
    end else begin
      st_d.af_word = af_status_select;
      st_d.ae_word = ae_status_select;
    end
    st_d.af_bus = af_vec[STAT_W*st_d.af_word +: STAT_W];
    st_d.ae_bus = ae_vec[STAT_W*st_d.ae_word +: STAT_W];
    for (int i = 0; i < STAT_W; i++) begin
      if ((STAT_W*st_d.ae_word + i) >= st_q.nq) begin
        st_d.ae_bus[i] = 1'b0;
      end
    end

    // Master reset clears the queues and keeps sampling the setup pins,
    // so the value present at its release is the one that sticks.
    if (!master_reset_n) begin
      st_d       = '0;
      st_d.cfg   = CFG_RESET;
      st_d.strap = strap;
      st_d.flags = '{queue_full_flag: 1'b1, almost_full_flag: 1'b1,
                     queue_empty_flag: 1'b1, almost_empty_flag: 1'b1,
                     packet_ready_n: 1'b1};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q       <= '0;
      st_q.cfg   <= CFG_RESET;
      st_q.flags <= '{queue_full_flag: 1'b1, almost_full_flag: 1'b1,
                      queue_empty_flag: 1'b1, almost_empty_flag: 1'b1,
                      packet_ready_n: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_waddr] <= stage_out_data[WORD_W-1:0];
    end
  end

  assign config_done             = st_q.cfg == CFG_RUN;
  assign expansion_master        = st_q.strap.master;
  assign write_ready             = st_q.wready;
  assign read_data               = st_q.rdata;
  assign read_valid              = st_q.rvalid;
  assign flags                   = st_q.flags;
  assign almost_full_status_bus  = st_q.af_bus;
  assign almost_empty_status_bus = st_q.ae_bus;
  assign af_status_word          = st_q.af_word;
  assign ae_status_word          = st_q.ae_word;
endmodule

`default_nettype wire

// File: verif/mqf_top_sva.sv
// Port-level checks for the multi-queue FIFO top.
// Assumes the setup pins stay still while the queues run.
`timescale 1ns/1ps
`default_nettype none

module mqf_top_sva #(
  parameter int unsigned NUM_Q = 8
) (
  // Clock and resets
  input wire logic                       clock,
  input wire logic                       nrst,
  input wire logic                       master_reset_n,
  // Setup
  input wire mqf_pkg::mqf_strap_t        strap,
  input wire logic                       config_done,
  input wire logic                       expansion_master,
  // Ports and flags
  input wire logic [mqf_pkg::QA_W-1:0]   write_queue_address,
  input wire logic                       write_ready,
  input wire logic                       read_enable,
  input wire logic                       read_valid,
  input wire logic [mqf_pkg::PORT_W-1:0] read_data,
  input wire mqf_pkg::mqf_flags_t        flags
);
  import mqf_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_release;
    $rose(master_reset_n) && $stable(strap);
  endsequence

  sequence s_read_taken;
    $past(read_enable) && $past(config_done);
  endsequence

  property p_valid_cause;
    read_valid |-> s_read_taken;
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("read answer without a taken request");

  property p_data_hold;
    !read_valid && master_reset_n |-> $stable(read_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read data moved without a read");

  property p_ready_gate;
    !config_done |=> !write_ready;
  endproperty
  a_ready_gate: assert property (p_ready_gate)
    else $error("write ready before configuration");

  property p_role_latch;
    s_release |-> ##3 expansion_master == $past(strap.master, 3);
  endproperty
  a_role_latch: assert property (p_role_latch)
    else $error("expansion role not latched");

  property p_default_up;
    s_release and (strap.prog_mode != MQF_PROG_SERIAL) |-> ##[1:4] config_done;
  endproperty
  a_default_up: assert property (p_default_up)
    else $error("default setup did not come up");

  property p_cfg_hold;
    config_done && master_reset_n |=> config_done;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration lost without master reset");

  property p_no_packet;
    config_done && !strap.packet_mode |-> flags.packet_ready_n;
  endproperty
  a_no_packet: assert property (p_no_packet)
    else $error("packet ready outside packet mode");

  property p_unused_full;
    config_done && write_queue_address >= NUM_Q |=> flags.queue_full_flag;
  endproperty
  a_unused_full: assert property (p_unused_full)
    else $error("unconfigured queue not shown full");
endmodule

bind mqf_top mqf_top_sva mqf_top_sva_inst (
  .clock, .nrst, .master_reset_n, .strap, .config_done, .expansion_master,
  .write_queue_address, .write_ready, .read_enable, .read_valid,
  .read_data, .flags
);

`default_nettype wire

// File: verif/mqf_reader_model.sv
// Downstream reader that asks for data promptly or with stalls.
// Assumes the bench steers the read queue address itself.
`timescale 1ns/1ps
`default_nettype none

module mqf_reader_model (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  nrst,
  // Control from the bench
  input  wire logic  go,
  input  wire logic  slow,
  // Read port
  output logic       read_enable,
  input  wire logic  read_valid,
  output logic [15:0] got_count
);
  logic stall_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stall_q     <= 1'h0;
      read_enable <= 1'h0;
      got_count   <= 16'h0000;
    end else begin
      stall_q     <= ~stall_q;
      // A slow reader asks only every other cycle, so stored words pile up.
      read_enable <= go && !(slow && stall_q);
      got_count   <= got_count + {15'h0000, read_valid};
    end
  end
endmodule

`default_nettype wire

// File: verif/mqf_top_tb.sv
// Self-checking bench for the multi-queue FIFO in its default setup.
// Assumes the package, design and reader model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module mqf_top_tb;
  import mqf_pkg::*;

  logic              clock, nrst, master_reset_n, go, slow;
  mqf_strap_t        strap;
  logic              serial_enable, serial_data, config_done;
  logic              expansion_master, write_enable, write_ready;
  logic              read_enable, read_valid;
  logic [QA_W-1:0]   write_queue_address, read_queue_address, rq_q;
  logic [PORT_W-1:0] write_data, read_data, last_data;
  mqf_flags_t        flags;
  logic [SW_W-1:0]   af_status_select, ae_status_select;
  logic [SW_W-1:0]   af_status_word, ae_status_word;
  logic [STAT_W-1:0] almost_full_status_bus, almost_empty_status_bus;
  logic [15:0]       got_count, g0;
  logic [31:0]       rnd;
  logic [PORT_W-1:0] exp_q [8][$];
  int                err_count, n_compared, cycles;

  mqf_top mqf_top_inst (
    .clock, .nrst, .master_reset_n, .strap, .serial_enable, .serial_data,
    .config_done, .expansion_master, .write_queue_address, .write_enable,
    .write_data, .write_ready, .read_queue_address, .read_enable,
    .read_data, .read_valid, .flags, .af_status_select, .ae_status_select,
    .almost_full_status_bus, .almost_empty_status_bus,
    .af_status_word, .ae_status_word
  );

  mqf_reader_model mqf_reader_model_inst (
    .clock, .nrst, .go, .slow, .read_enable, .read_valid, .got_count
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Writes go out every other cycle so the staging path never backs up.
  task automatic wr(input logic [QA_W-1:0] q, input logic [PORT_W-1:0] d);
    @(posedge clock);
    write_queue_address <= q;
    write_data          <= d;
    write_enable        <= 1'h1;
    @(posedge clock);
    write_enable        <= 1'h0;
    if (q < DEF_QUEUES && exp_q[q[2:0]].size() < BLOCK_WORDS)
      exp_q[q[2:0]].push_back(d);
  endtask

  task automatic settle();
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask

  always #10 clock = ~clock;

  always @(posedge clock) begin
    rq_q   <= read_queue_address;
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      err_count++;
      results();
    end
  end

  always @(negedge clock) begin
    if (read_valid === 1'h1) begin
      last_data = read_data;
      if (rq_q < DEF_QUEUES && exp_q[rq_q[2:0]].size() > 0)
        check(read_data, exp_q[rq_q[2:0]].pop_front());
      else
        check(read_valid, 1'h0);
    end
  end

  initial begin
    clock = 1'h0;
    nrst = 1'h0;
    master_reset_n = 1'h1;
    strap = '{MQF_PROG_DEFAULT, 1'h0, 1'h0, 1'h1, MQF_W36, MQF_W36};
    {serial_enable, serial_data, go, slow, write_enable} = 5'h00;
    {af_status_select, ae_status_select} = 4'h0;
    write_queue_address = '0;
    read_queue_address = '0;
    write_data = '0;
    rnd = 32'h0000_0014;
    repeat (6) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    master_reset_n <= 1'h0;
    repeat (2) @(posedge clock);
    master_reset_n <= 1'h1;
    for (int i = 0; i < 8 && config_done !== 1'h1; i++)
      @(posedge clock);
    check(config_done, 1'h1);
    check(expansion_master, 1'h1);
    // Mixed traffic, sometimes aimed at queues that do not exist.
    go <= 1'h1;
    for (int n = 0; n < 200; n++) begin
      rnd = xs(rnd);
      slow <= rnd[31];
      if (rnd[15:14] == 2'h0)
        read_queue_address <= {2'h0, rnd[18:16]};
      wr(rnd[5:4] == 2'h0 ? rnd[12:8] : {2'h0, rnd[10:8]},
         {rnd[3:0], xs(rnd)});
    end
    slow <= 1'h0;
    for (int r = 0; r < 16; r++) begin
      read_queue_address <= QA_W'(r % 8);
      repeat (60) @(posedge clock);
    end
    for (int q = 0; q < 8; q++)
      check(exp_q[q].size(), 0);
    read_queue_address <= 5'h05;
    settle();
    check(read_data, last_data);
    check(flags.queue_empty_flag, 1'h1);
    check(flags.almost_empty_flag, 1'h1);
    check(almost_empty_status_bus, 8'hff);
    check({af_status_word, ae_status_word}, 4'h0);
    // Fill one queue across the almost-full boundary and past full.
    @(posedge clock);
    go <= 1'h0;
    for (int n = 0; n < 247; n++)
      wr(5'h03, {4'h3, 32'(n)});
    settle();
    check(almost_full_status_bus, 8'h00);
    wr(5'h03, {4'h3, 32'h0000_00f7});
    settle();
    check(almost_full_status_bus, 8'h08);
    check(flags.almost_full_flag, 1'h1);
    check(flags.queue_full_flag, 1'h0);
    for (int n = 248; n < 260; n++)
      wr(5'h03, {4'h3, 32'(n)});
    settle();
    check(flags.queue_full_flag, 1'h1);
    check(write_ready, 1'h0);
    @(posedge clock);
    read_queue_address <= 5'h03;
    settle();
    check(flags.queue_empty_flag, 1'h0);
    check(almost_empty_status_bus, 8'hf7);
    @(posedge clock);
    g0 = got_count;
    slow <= 1'h1;
    go <= 1'h1;
    repeat (700) @(posedge clock);
    check(got_count - g0, 16'h0100);
    // Packet mode after a second master reset: one word is a whole packet.
    go <= 1'h0;
    slow <= 1'h0;
    read_queue_address <= 5'h00;
    strap.packet_mode <= 1'h1;
    master_reset_n <= 1'h0;
    repeat (2) @(posedge clock);
    master_reset_n <= 1'h1;
    repeat (3) @(posedge clock);
    wr(5'h00, 36'h0_0002_0100);
    settle();
    check(flags.packet_ready_n, 1'h0);
    @(posedge clock);
    go <= 1'h1;
    settle();
    check(flags.packet_ready_n, 1'h1);
    results();
  end
endmodule

`default_nettype wire
